// >>> hw/sls_pkg.sv
// Purpose: shared constants and types for the split/lap stopwatch
// Assumes: ref_clk at 10 MHz
// Notes:   time base codes select the unit of the output value
`default_nettype none
package sls_pkg;
	// ******************************************************
	// clock and time base
	// ******************************************************
	localparam int unsigned CLK_HZ        = 10000000;
	localparam int unsigned TICK_10MS_MS  = 10;
	localparam int unsigned CYC_PER_10MS  = CLK_HZ / 1000 * TICK_10MS_MS;
	localparam int unsigned HUND_PER_SEC  = 100;
	localparam int unsigned SEC_PER_MIN   = 60;
	localparam int unsigned MIN_PER_HOUR  = 60;
	localparam int unsigned VALUE_W       = 32;
	localparam logic [31:0] VALUE_RST     = 32'h0000_0000;

	typedef enum logic [1:0]
	{
		SLS_BASE_HOUR = 2'b00,
		SLS_BASE_MIN  = 2'b01,
		SLS_BASE_SEC  = 2'b10,
		SLS_BASE_HUND = 2'b11
	} sls_base_t;

	typedef struct packed
	{
		logic enable;
		logic split;
		logic clear;
	} sls_ctrl_t;
endpackage : sls_pkg
`default_nettype wire

// >>> hw/sls_stopwatch.sv
// Purpose: elapsed-time stopwatch with split capture
// Assumes: inputs come from logic on ref_clk; rst synchronous active high
// Notes:   count width and prescale are parameters
`default_nettype none
module sls_stopwatch
	import sls_pkg::*;
#(
	parameter int unsigned CYC_10MS = CYC_PER_10MS,
	parameter int unsigned W        = VALUE_W
)
(
	input  wire logic         ref_clk,           // system clock
	input  wire logic         rst,               // synchronous reset
	input  wire logic         clk_en,            // freezes all state when low; rst and ctrl.clear still act
	input  wire sls_ctrl_t    ctrl,              // enable, split, clear inputs
	input  wire sls_base_t    time_base,         // output unit select
	output logic [W-1:0]      time_value_output  // shown value in selected unit
);
	// ******************************************************
	// elaboration checks
	// ******************************************************
	if (CYC_10MS < 1) $error("CYC_10MS must be at least 1");
	if (W < 8 || W > 32) $error("W must be 8..32");

	localparam int unsigned PW = $clog2(CYC_10MS + 1);

	logic [PW-1:0] pre_reg;
	logic [6:0]    hund_reg;
	logic [5:0]    sec_reg;
	logic [5:0]    min_reg;
	logic [W-1:0]  hour_reg;
	logic [6:0]    lap_hund_reg;
	logic [5:0]    lap_sec_reg;
	logic [5:0]    lap_min_reg;
	logic [W-1:0]  lap_hour_reg;
	logic          en_d_reg;
	logic          split_d_reg;
	logic          show_lap_reg;
	logic          tick;
	logic          en_rise;
	logic          split_rise;
	logic          split_fall;

	assign en_rise    = ctrl.enable & ~en_d_reg;
	assign split_rise = ctrl.split & ~split_d_reg;
	assign split_fall = ~ctrl.split & split_d_reg;
	assign tick       = ctrl.enable && !en_rise && (pre_reg == PW'(CYC_10MS - 1));

	// converts a lap or elapsed time into the selected unit
	function automatic logic [W-1:0] to_unit(input sls_base_t b, input logic [W-1:0] h,
		input logic [5:0] m, input logic [5:0] s, input logic [6:0] c);
		logic [W+16:0] v;
		v = '0;
		unique case (b)
			SLS_BASE_HOUR: v = (W+17)'(h);
			SLS_BASE_MIN:  v = (W+17)'(h) * (W+17)'(MIN_PER_HOUR) + (W+17)'(m);
			SLS_BASE_SEC:  v = ((W+17)'(h) * (W+17)'(MIN_PER_HOUR) + (W+17)'(m))
				* (W+17)'(SEC_PER_MIN) + (W+17)'(s);
			SLS_BASE_HUND: v = (((W+17)'(h) * (W+17)'(MIN_PER_HOUR) + (W+17)'(m))
				* (W+17)'(SEC_PER_MIN) + (W+17)'(s)) * (W+17)'(HUND_PER_SEC) + (W+17)'(c);
		endcase
		return v[W-1:0];
	endfunction : to_unit

	// ******************************************************
	// edge history
	// ******************************************************
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			en_d_reg    <= 1'b0;
			split_d_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			en_d_reg    <= ctrl.enable;
			split_d_reg <= ctrl.split;
		end
	end

	// ******************************************************
	// 10 ms prescaler
	// ******************************************************
	always_ff @(posedge ref_clk)
	begin
		if (rst || ctrl.clear)
			pre_reg <= '0;
		else if (clk_en)
		begin
			if (en_rise || !ctrl.enable || tick)
				pre_reg <= '0;
			else
				pre_reg <= pre_reg + PW'(1);
		end
	end

	// ******************************************************
	// elapsed time
	// ******************************************************
	always_ff @(posedge ref_clk)
	begin
		if (rst || ctrl.clear)
		begin
			hund_reg <= '0;
			sec_reg  <= '0;
			min_reg  <= '0;
			hour_reg <= '0;
		end
		else if (clk_en)
		begin
			if (en_rise)
			begin
				hund_reg <= '0;
				sec_reg  <= '0;
				min_reg  <= '0;
				hour_reg <= '0;
			end
			else if (tick)
			begin
				if (hund_reg == 7'(HUND_PER_SEC - 1))
				begin
					hund_reg <= '0;
					if (sec_reg == 6'(SEC_PER_MIN - 1))
					begin
						sec_reg <= '0;
						if (min_reg == 6'(MIN_PER_HOUR - 1))
						begin
							min_reg <= '0;
							if (hour_reg != '1)
								hour_reg <= hour_reg + W'(1);
						end
						else
							min_reg <= min_reg + 6'd1;
					end
					else
						sec_reg <= sec_reg + 6'd1;
				end
				else
					hund_reg <= hund_reg + 7'd1;
			end
		end
	end

	// ******************************************************
	// lap capture and output select
	// ******************************************************
	always_ff @(posedge ref_clk)
	begin
		if (rst || ctrl.clear)
		begin
			lap_hund_reg <= '0;
			lap_sec_reg  <= '0;
			lap_min_reg  <= '0;
			lap_hour_reg <= '0;
			show_lap_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (split_rise)
			begin
				lap_hund_reg <= hund_reg;
				lap_sec_reg  <= sec_reg;
				lap_min_reg  <= min_reg;
				lap_hour_reg <= hour_reg;
				show_lap_reg <= 1'b1;
			end
			else if (split_fall)
				show_lap_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst || ctrl.clear)
			time_value_output <= W'(VALUE_RST);
		else if (clk_en)
		begin
			if (show_lap_reg)
				time_value_output <= to_unit(time_base, lap_hour_reg, lap_min_reg,
					lap_sec_reg, lap_hund_reg);
			else
				time_value_output <= to_unit(time_base, hour_reg, min_reg,
					sec_reg, hund_reg);
		end
	end

	// ******************************************************
	// assertions
	// ******************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	AST_EN_RISE_CLEARS: assert property (clk_en && !ctrl.clear && en_rise |=>
		hund_reg == '0 && sec_reg == '0 && min_reg == '0 && hour_reg == '0)
		else $error("elapsed time not cleared on enable rise");
	AST_HOLD_WHEN_OFF: assert property (clk_en && !ctrl.clear && !ctrl.enable |=>
		$stable(hund_reg) && $stable(sec_reg))
		else $error("elapsed time moved while disabled");
	AST_LAP_CAPTURE: assert property (clk_en && !ctrl.clear && split_rise |=>
		show_lap_reg && lap_hund_reg == $past(hund_reg))
		else $error("lap not captured on split rise");
	AST_SPLIT_FALL: assert property (clk_en && !ctrl.clear && split_fall |=>
		!show_lap_reg)
		else $error("output did not return to elapsed time");
	AST_CLEAR: assert property (ctrl.clear |=> hour_reg == '0 && lap_hour_reg == '0
		&& time_value_output == '0)
		else $error("clear did not zero the times");
	AST_HUND_UNIT: assert property (clk_en && !ctrl.clear && !show_lap_reg
		&& time_base == SLS_BASE_HUND && hour_reg == '0 && min_reg == '0 |=>
		time_value_output == W'(W'($past(sec_reg)) * HUND_PER_SEC + W'($past(hund_reg))))
		else $error("hundredths output wrong");
	AST_RUN_WHILE_LAP: assert property (clk_en && !ctrl.clear && tick
		&& show_lap_reg |=> hund_reg != $past(hund_reg))
		else $error("count stalled while split held");
	AST_TICK_PERIOD: assert property (clk_en && !ctrl.clear && !en_rise
		&& pre_reg != PW'(CYC_10MS - 1) |=> $stable(hund_reg))
		else $error("count moved off the prescale tick");
	AST_LAP_SHOWN: assert property (clk_en && !ctrl.clear && show_lap_reg
		&& time_base == SLS_BASE_HOUR |=> time_value_output == $past(lap_hour_reg))
		else $error("lap value not shown");
	AST_RUN_SHOWN: assert property (clk_en && !ctrl.clear && !show_lap_reg
		&& time_base == SLS_BASE_HOUR |=> time_value_output == $past(hour_reg))
		else $error("elapsed value not shown");

	COV_LAP: cover property (split_rise && ctrl.enable);
	COV_FREEZE: cover property (en_d_reg && !ctrl.enable);
	COV_TICK: cover property (tick ##[1:1000] tick);
	COV_CLEAR: cover property (ctrl.clear && ctrl.enable);
endmodule : sls_stopwatch
`default_nettype wire

// >>> sim/sls_ctrl_src.sv
// Purpose: far-side logic block that drives the stopwatch control inputs
// Assumes: requests change off the rising edge
// Notes:   outputs follow the requests, which move on the falling edge of ref_clk
`default_nettype none
module sls_ctrl_src
	import sls_pkg::*;
(
	input  wire logic      ref_clk,  // system clock
	input  wire logic      en_req,   // wanted enable level
	input  wire logic      lap_req,  // wanted split level
	input  wire logic      clr_req,  // wanted clear level
	output var  sls_ctrl_t ctrl      // packed control word
);
	timeunit 1ns;
	timeprecision 1ns;
	// no sampling of its own: a negedge process would race the bench's negedge writes
	always_comb
		ctrl = '{enable: en_req, split: lap_req, clear: clr_req};
endmodule : sls_ctrl_src
`default_nettype wire

// >>> sim/testbench.sv
// Purpose: self-checking bench for the split/lap stopwatch
// Assumes: prescale of 4 cycles per hundredth
// Notes:   counts are judged within up to two ticks of slack
`default_nettype none
module testbench
	import sls_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned CYC = 4;
	logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, en = 1'b0, lap = 1'b0, clr = 1'b0;
	sls_base_t   time_base = SLS_BASE_HUND;
	sls_ctrl_t   ctrl;
	logic [31:0] tv, hold;
	int          failures = 0, checks_done = 0;
	always #50 ref_clk = ~ref_clk;
	sls_ctrl_src i_sls_ctrl_src (.ref_clk(ref_clk), .en_req(en), .lap_req(lap),
		.clr_req(clr), .ctrl(ctrl));
	sls_stopwatch #(.CYC_10MS(CYC), .W(32)) i_sls_stopwatch (.ref_clk(ref_clk), .rst(rst),
		.clk_en(clk_en), .ctrl(ctrl), .time_base(time_base), .time_value_output(tv));
	// ******************************************************
	// helpers
	// ******************************************************
	task automatic step(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : step
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] tol);
		checks_done++;
		if ((^tv === 1'bx) || (tv > exp + tol) || (tv + tol < exp))
		begin
			failures++;
			$display("unexpected %s: expected %0d seen %0d", what, exp, tv);
		end
	endtask : check
	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	// ******************************************************
	// scenarios
	// ******************************************************
	task automatic t_count_freeze;
		en = 1'b1;
		step(200);
		check("running", 32'h32, 32'h2);
		step(200);
		en = 1'b0;
		step(4);
		hold = tv;
		check("frozen", 32'h64, 32'h2);
		step(40);
		check("held", hold, 32'h0);
		$display("test count_freeze done");
	endtask : t_count_freeze
	task automatic t_bases;
		time_base = SLS_BASE_SEC;
		step(3);
		check("seconds", hold / 100, 32'h0);
		time_base = SLS_BASE_MIN;
		step(3);
		check("minutes", 32'h0, 32'h0);
		time_base = SLS_BASE_HOUR;
		step(3);
		check("hours", 32'h0, 32'h0);
		time_base = SLS_BASE_HUND;
		step(3);
		check("hundredths", hold, 32'h0);
		$display("test bases done");
	endtask : t_bases
	task automatic t_split;
		en = 1'b1;
		step(6);
		check("restart", 32'h0, 32'h1);
		step(74);
		lap = 1'b1;
		step(4);
		hold = tv;
		check("lap", 32'h14, 32'h2);
		step(80);
		check("lap shown", hold, 32'h0);
		lap = 1'b0;
		step(4);
		check("running after lap", 32'h29, 32'h2);
		lap = 1'b1;
		step(4);
		hold = tv;
		check("second lap", 32'h29, 32'h2);
		step(20);
		en = 1'b0;
		step(4);
		check("lap while stopped", hold, 32'h0);
		lap = 1'b0;
		step(4);
		check("frozen after lap", 32'h2f, 32'h2);
		$display("test split done");
	endtask : t_split
	task automatic t_clear;
		en = 1'b1;
		clr = 1'b1;
		step(40);
		check("clear beats enable", 32'h0, 32'h0);
		clr = 1'b0;
		step(40);
		check("count after clear", 32'ha, 32'h2);
		lap = 1'b1;
		step(4);
		check("lap before clear", 32'ha, 32'h2);
		clr = 1'b1;
		step(4);
		check("clear while lap", 32'h0, 32'h0);
		clr = 1'b0;
		step(4);
		check("lap cleared", 32'h0, 32'h1);
		lap = 1'b0;
		step(40);
		rst = 1'b1;
		step(3);
		check("reset", 32'h0, 32'h0);
		rst = 1'b0;
		step(6);
		check("restart after reset", 32'h0, 32'h1);
		hold = tv;
		clk_en = 1'b0;
		step(20);
		check("clock enable freeze", hold, 32'h0);
		clk_en = 1'b1;
		$display("test clear done");
	endtask : t_clear
	initial
	begin
		step(3);
		rst = 1'b0;
		check("after reset", 32'h0, 32'h0);
		t_count_freeze();
		t_bases();
		t_split();
		t_clear();
		give_verdict();
	end
	initial
	begin
		step(5000);
		failures++;
		$display("unexpected timeout: expected finish seen hang");
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
